// file: rtl/frx_pkg.sv
// Package for the file-register instruction execution block.
// Assumes a 14-bit instruction word fed one per instruction cycle.
package frx_pkg;

   // ****************************************
   // Widths and positions
   // ****************************************
   localparam int FRX_DATA_W = 8;
   localparam int FRX_ADDR_W = 7;
   localparam int FRX_PC_W = 15;
   localparam int FRX_LIT_BRANCH_W = 11;
   localparam int FRX_DEST_BIT = 7;
   localparam int FRX_LATCH_LO = 3; // Latch bits 6:3 feed PC 14:11
   localparam int FRX_LATCH_HI = 6;

   // ****************************************
   // Reset values and constants
   // ****************************************
   localparam logic [7:0] FRX_ZERO_BYTE = 8'h00;
   localparam logic [14:0] FRX_PC_RESET = 15'h0000;
   localparam logic [7:0] FRX_W_RESET = 8'h00;
   localparam logic [6:0] FRX_FILE_COUNT = 7'h7f; // Highest file address 127

   // ****************************************
   // Opcode patterns (14-bit word)
   // ****************************************
   localparam logic [13:0] FRX_OP_CLEAR_FILE = 14'h0180; // 00 0001 1fff ffff
   localparam logic [13:0] FRX_OP_CLEAR_ACCUM = 14'h0100; // 00 0001 0xxx xxxx
   localparam logic [5:0] FRX_OP_DEC = 6'h03; // 00 0011 dfff ffff
   localparam logic [5:0] FRX_OP_DEC_SKIP = 6'h0b; // 00 1011 dfff ffff
   localparam logic [5:0] FRX_OP_INC_SKIP = 6'h0f; // 00 1111 dfff ffff
   localparam logic [2:0] FRX_OP_BRANCH = 3'h5; // 10 1kkk kkkk kkkk
   localparam logic [5:0] FRX_OP_OR_LIT = 6'h38; // 11 1000 kkkk kkkk

   typedef enum logic [7:0] {
      FRX_I_NONE = 8'h01,
      FRX_I_CLR_FILE = 8'h02,
      FRX_I_CLRA = 8'h04,
      FRX_I_DEC = 8'h08,
      FRX_I_DSKP = 8'h10,
      FRX_I_ISKP = 8'h20,
      FRX_I_BRAN = 8'h40,
      FRX_I_ORL = 8'h80
   } frx_instr_t;

   // Execution state: run, or flush one fetched word
   typedef enum logic [1:0] {
      FRX_S_RUN = 2'b01,
      FRX_S_FLUSH = 2'b10
   } frx_state_t;

   // Write to the file memory
   typedef struct packed {
      logic en;
      logic [6:0] addr;
      logic [7:0] data;
   } frx_file_wr_t;

endpackage : frx_pkg

// file: rtl/frx_decode.sv
// Decoder of the 14-bit instruction word into the executed subset.
// Assumes the word is valid in the cycle it is presented.
`timescale 1ns/1ps
module frx_decode
   import frx_pkg::*;
(
   input wire logic [13:0] instr,
   output frx_instr_t kind
);

   // Unknown words decode to none and leave all state alone except the PC, which still advances
   always_comb begin
      kind = FRX_I_NONE;
      if ((instr & 14'h3f80) == FRX_OP_CLEAR_FILE) begin
         kind = FRX_I_CLR_FILE;
      end else if ((instr & 14'h3f80) == FRX_OP_CLEAR_ACCUM) begin
         kind = FRX_I_CLRA;
      end else if (instr[13:8] == FRX_OP_DEC) begin
         kind = FRX_I_DEC;
      end else if (instr[13:8] == FRX_OP_DEC_SKIP) begin
         kind = FRX_I_DSKP;
      end else if (instr[13:8] == FRX_OP_INC_SKIP) begin
         kind = FRX_I_ISKP;
      end else if (instr[13:11] == FRX_OP_BRANCH) begin
         kind = FRX_I_BRAN;
      end else if (instr[13:8] == FRX_OP_OR_LIT) begin
         kind = FRX_I_ORL;
      end
   end

endmodule : frx_decode

// file: rtl/frx_exec.sv
// Execution core for clear, decrement, increment-skip, OR literal and branch.
// Assumes one instruction word per clock, and that the file memory returns
// file_rd_data combinationally for file_rd_addr.
// Functional notes
// - Clear-file writes zero to the 7-bit addressed register and sets zero flag.
// - Clear-accumulator loads zero into working register and sets zero flag.
// - Decrement-file subtracts one; destination bit picks working or file register.
// - Decrement-skip keeps flags; zero result replaces next instruction by a no-op.
// - Increment-skip keeps flags; zero result discards next instruction as no-op.
// - Branch loads 11-bit literal into PC 10:0, latch bits 6:3 into PC 14:11.
// - OR-literal ORs 8-bit literal into working register and updates zero flag.
// - Destination bit is one bit: 0 working register, 1 file register.
`timescale 1ns/1ps
module frx_exec
   import frx_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [13:0] instr,
   input wire logic [7:0] program_counter_high_latch,
   input wire logic [7:0] file_rd_data,
   output logic [6:0] file_rd_addr,
   output frx_file_wr_t file_wr,
   output logic [7:0] accum,
   output logic zero_flag,
   output logic [14:0] pc,
   output logic flush
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic is_zero(input logic [7:0] v);
      return v == FRX_ZERO_BYTE;
   endfunction : is_zero

   frx_instr_t kind;
   frx_state_t state_reg, state_next;
   logic [7:0] accum_reg, accum_next;
   logic zero_reg, zero_next;
   logic [14:0] pc_reg, pc_next;
   frx_file_wr_t wr_reg, wr_next;
   logic [7:0] result;
   logic [7:0] operand;
   logic dest_file;
   logic executing;

   frx_decode u_decode (
      .instr(instr),
      .kind(kind)
   );

   // ****************************************
   // Datapath
   // ****************************************
   assign file_rd_addr = instr[FRX_ADDR_W-1:0];
   assign dest_file = instr[FRX_DEST_BIT];
   assign executing = (state_reg == FRX_S_RUN);

   // The file write lands one edge after the writing instruction; forward it so
   // a back-to-back instruction on the same register sees the new value
   assign operand = (wr_reg.en && (wr_reg.addr == file_rd_addr)) ?
      wr_reg.data : file_rd_data;

   // Arithmetic result shared by the decrement, skip and OR-literal forms
   always_comb begin
      unique case (kind)
         FRX_I_DEC, FRX_I_DSKP: result = operand - 8'h01;
         FRX_I_ISKP: result = operand + 8'h01;
         FRX_I_ORL: result = accum_reg | instr[7:0];
         default: result = FRX_ZERO_BYTE;
      endcase
   end

   // Next state; a flushed slot executes nothing but still advances the PC
   always_comb begin
      state_next = FRX_S_RUN;
      accum_next = accum_reg;
      zero_next = zero_reg;
      pc_next = pc_reg + 15'h0001;
      wr_next = '0;
      if (executing) begin
         unique case (kind)
            FRX_I_CLR_FILE: begin
               wr_next = '{en: 1'b1, addr: file_rd_addr, data: FRX_ZERO_BYTE};
               zero_next = 1'b1;
            end
            FRX_I_CLRA: begin
               accum_next = FRX_ZERO_BYTE;
               zero_next = 1'b1;
            end
            FRX_I_DEC: begin
               zero_next = is_zero(result);
               if (dest_file) begin
                  wr_next = '{en: 1'b1, addr: file_rd_addr, data: result};
               end else begin
                  accum_next = result;
               end
            end
            FRX_I_DSKP, FRX_I_ISKP: begin
               // Flags held on purpose; only the skip depends on the result
               if (dest_file) begin
                  wr_next = '{en: 1'b1, addr: file_rd_addr, data: result};
               end else begin
                  accum_next = result;
               end
               if (is_zero(result)) begin
                  state_next = FRX_S_FLUSH;
               end
            end
            FRX_I_BRAN: begin
               pc_next = {program_counter_high_latch[FRX_LATCH_HI:FRX_LATCH_LO],
                  instr[FRX_LIT_BRANCH_W-1:0]};
               state_next = FRX_S_FLUSH;
            end
            FRX_I_ORL: begin
               accum_next = result;
               zero_next = is_zero(result);
            end
            FRX_I_NONE: begin
               accum_next = accum_reg;
            end
         endcase
      end
   end

   // Registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= FRX_S_RUN;
         accum_reg <= FRX_W_RESET;
         zero_reg <= 1'b0;
         pc_reg <= FRX_PC_RESET;
         wr_reg <= '0;
      end else begin
         state_reg <= state_next;
         accum_reg <= accum_next;
         zero_reg <= zero_next;
         pc_reg <= pc_next;
         wr_reg <= wr_next;
      end
   end

   assign accum = accum_reg;
   assign zero_flag = zero_reg;
   assign pc = pc_reg;
   assign file_wr = wr_reg;
   assign flush = !executing;

   // ****************************************
   // Assertions
   // ****************************************
   property p_clear_file;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_CLR_FILE) |=>
         (file_wr.en && file_wr.data == 8'h00 && zero_flag
          && file_wr.addr == $past(file_rd_addr));
   endproperty
   a_clear_file: assert property (p_clear_file) else $error("clear file failed");

   property p_clra;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_CLRA) |=> (accum == 8'h00 && zero_flag && !file_wr.en);
   endproperty
   a_clra: assert property (p_clra) else $error("clear accum failed");

   property p_dec;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_DEC && !dest_file) |=>
         (accum == $past(operand) - 8'h01);
   endproperty
   a_dec: assert property (p_dec) else $error("decrement to accum wrong");

   property p_dskp;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_DSKP && operand == 8'h01) |=>
         ($stable(zero_flag) && flush) ##1 !flush;
   endproperty
   a_dskp: assert property (p_dskp) else $error("decrement skip wrong");

   property p_iskp;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_ISKP && dest_file) |=>
         (file_wr.data == $past(operand) + 8'h01 && $stable(zero_flag)
          && flush == ($past(operand) == 8'hff));
   endproperty
   a_iskp: assert property (p_iskp) else $error("increment skip wrong");

   property p_bran;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_BRAN) |=>
         (pc == {$past(program_counter_high_latch[6:3]), $past(instr[10:0])}) ##1
         (pc == $past(pc) + 15'h0001);
   endproperty
   a_bran: assert property (p_bran) else $error("branch target wrong");

   property p_orl;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_ORL) |=>
         (accum == ($past(accum) | $past(instr[7:0])) && zero_flag == (accum == 8'h00));
   endproperty
   a_orl: assert property (p_orl) else $error("or literal wrong");

   property p_dest;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_DEC && dest_file) |=> (file_wr.en && $stable(accum));
   endproperty
   a_dest: assert property (p_dest) else $error("destination select wrong");

   property p_flush;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_BRAN) |=> (flush && !file_wr.en) ##1 (!flush && $stable(accum));
   endproperty
   a_flush: assert property (p_flush) else $error("branch flush wrong");

   property p_skip_slot;
      @(posedge clk) disable iff (sys_rst)
      (!executing) |=>
         (!file_wr.en && $stable(accum) && $stable(zero_flag) && !flush);
   endproperty
   a_skip_slot: assert property (p_skip_slot) else $error("discarded slot acted");

   property p_dec_zero;
      @(posedge clk) disable iff (sys_rst)
      (executing && kind == FRX_I_DEC) |=> (zero_flag == ($past(operand) == 8'h01));
   endproperty
   a_dec_zero: assert property (p_dec_zero) else $error("decrement zero flag wrong");

endmodule : frx_exec

// file: test/file_reg_instr_exec_tb.sv
// Self-checking bench for the file-register execution core frx_exec.
// Assumes a combinational file memory, modelled here as a 128-byte array.
`timescale 1ns/1ps
module file_reg_instr_exec_tb
   import frx_pkg::*;
;
   // ****************************************
   // Clock, reset, memory model
   // ****************************************
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [13:0] instr = 14'h0000;
   logic [7:0] latch = 8'h00;
   logic [7:0] mem [0:127];
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   frx_file_wr_t wr;
   logic [7:0] accum;
   logic zero_flag;
   logic [14:0] pc;
   logic flush;
   int fail_count = 0;
   int compares = 0;
   always #20 clk = ~clk;
   assign rd_data = mem[rd_addr];
   // Writes land at the edge, like the real file memory
   always @(posedge clk) begin
      if (wr.en === 1'b1) mem[wr.addr] <= wr.data;
   end
   frx_exec i_dut (.clk(clk), .sys_rst(sys_rst), .instr(instr),
      .program_counter_high_latch(latch), .file_rd_data(rd_data),
      .file_rd_addr(rd_addr), .file_wr(wr), .accum(accum),
      .zero_flag(zero_flag), .pc(pc), .flush(flush));
   // ****************************************
   // Shared tasks
   // ****************************************
   // Present one word, then look just after the edge that takes it
   task automatic step(input logic [13:0] w);
      instr = w;
      @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic final_report;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // ****************************************
   // Scenarios
   // ****************************************
   // Clear at the top address, zero flag forced high
   task automatic t_clear_file;
      mem[127] = 8'h5a;
      step(FRX_OP_CLEAR_FILE | 14'h007f);
      chk("wr_en", 16'(1'b1), 16'(wr.en));
      chk("wr_addr", 16'(7'h7f), 16'(wr.addr));
      chk("wr_data", 16'(8'h00), 16'(wr.data));
      chk("zero", 16'(1'b1), 16'(zero_flag));
   endtask : t_clear_file
   // OR literal sequence, then clear of the working register
   task automatic t_or_clear;
      step({FRX_OP_OR_LIT, 8'h81});
      chk("accum", 16'(8'h81), 16'(accum));
      chk("zero", 16'(1'b0), 16'(zero_flag));
      step({FRX_OP_OR_LIT, 8'h24});
      chk("accum", 16'(8'ha5), 16'(accum));
      step(FRX_OP_CLEAR_ACCUM);
      chk("accum", 16'(8'h00), 16'(accum));
      chk("zero", 16'(1'b1), 16'(zero_flag));
      step({FRX_OP_OR_LIT, 8'h00});
      chk("zero", 16'(1'b1), 16'(zero_flag));
   endtask : t_or_clear
   // Decrement to each destination, including the wrap to ff
   task automatic t_dec;
      mem[3] = 8'h01;
      step({FRX_OP_DEC, 1'b0, 7'h03});
      chk("accum", 16'(8'h00), 16'(accum));
      chk("wr_en", 16'(1'b0), 16'(wr.en));
      step({FRX_OP_OR_LIT, 8'h33});
      step({FRX_OP_DEC, 1'b1, 7'h03});
      chk("wr_data", 16'(8'h00), 16'(wr.data));
      chk("accum", 16'(8'h33), 16'(accum));
      chk("zero", 16'(1'b1), 16'(zero_flag));
      step({FRX_OP_DEC, 1'b1, 7'h03});
      chk("wr_data", 16'(8'hff), 16'(wr.data));
      chk("zero", 16'(1'b0), 16'(zero_flag));
   endtask : t_dec
   // Skips: zero result flushes the next word, flags untouched
   task automatic t_skip;
      mem[4] = 8'h01;
      mem[6] = 8'h05;
      mem[7] = 8'hff;
      mem[8] = 8'h10;
      step({FRX_OP_DEC_SKIP, 1'b1, 7'h04});
      chk("wr_data", 16'(8'h00), 16'(wr.data));
      chk("flush", 16'(1'b1), 16'(flush));
      chk("zero", 16'(1'b0), 16'(zero_flag));
      step({FRX_OP_OR_LIT, 8'hff});
      chk("accum", 16'(8'h33), 16'(accum));
      chk("flush", 16'(1'b0), 16'(flush));
      step({FRX_OP_DEC_SKIP, 1'b0, 7'h06});
      chk("accum", 16'(8'h04), 16'(accum));
      chk("flush", 16'(1'b0), 16'(flush));
      step({FRX_OP_INC_SKIP, 1'b0, 7'h07});
      chk("accum", 16'(8'h00), 16'(accum));
      chk("flush", 16'(1'b1), 16'(flush));
      chk("zero", 16'(1'b0), 16'(zero_flag));
      step({FRX_OP_INC_SKIP, 1'b1, 7'h08});
      chk("wr_en", 16'(1'b0), 16'(wr.en));
      step({FRX_OP_INC_SKIP, 1'b1, 7'h08});
      chk("wr_data", 16'(8'h11), 16'(wr.data));
      chk("flush", 16'(1'b0), 16'(flush));
   endtask : t_skip
   // Branch to the top literal; latch bits outside 6:3 must not leak
   task automatic t_branch;
      latch = 8'hcd;
      step({FRX_OP_OR_LIT, 8'h0f});
      step({FRX_OP_BRANCH, 11'h7ff});
      chk("pc", 16'(15'h4fff), 16'(pc));
      chk("flush", 16'(1'b1), 16'(flush));
      step(FRX_OP_CLEAR_ACCUM);
      chk("accum", 16'(8'h0f), 16'(accum));
      chk("pc", 16'(15'h5000), 16'(pc));
      chk("flush", 16'(1'b0), 16'(flush));
   endtask : t_branch
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'h00;
      repeat (12) @(posedge clk);
      #1;
      chk("pc_rst", 16'(15'h0000), 16'(pc));
      chk("accum_rst", 16'(8'h00), 16'(accum));
      sys_rst = 1'b0;
      t_clear_file();
      t_or_clear();
      t_dec();
      t_skip();
      t_branch();
      final_report();
   end
endmodule : file_reg_instr_exec_tb
